//--- uml_modem_loop.sv
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

`include "uml_defs.svh"

// What this block does
// [R1] top three control bits read one, ignore writes
// [R2] loopback routes serializer into deserializer
// [R3] transmit pin held at one in loopback
// [R4] receive pin ignored during loopback
// [R5] loopback feeds modem inputs from modem outputs
// [R6] transmitted characters reach receiver directly
// [R7] loopback interrupt gate uses echo gate bit
// [R8] second general output gates serial interrupt normally
// [R9] first general output only stored normally
// [R10] request-to-send pin low when bit set
// [R11] terminal-ready pin low when bit set
// [R12] loop bit selects test mode, resets zero
// [R13] line break forces transmit low until cleared
// [R14] loopback status taken from output registers
module uml_modem_loop #(
    parameter int IRQ_SRCS = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial data path
    input wire logic txSerial,
    output logic rxToDeser,
    input wire logic serialLinePin,
    output logic serialTransmitPin,
    // modem pins, active low
    input wire uml_pkg::uml_modem_s modemPinN,
    output logic rtsN,
    output logic dtrN,
    output logic spareOutN,
    output logic gateOutN,
    // interrupt sources from the rest of the port
    input wire logic [IRQ_SRCS-1:0] portIrqReq,
    // interrupts
    output logic portIrq,
    output logic modemIrq
);

    // ************************************************************
    // registers
    // ************************************************************
    uml_pkg::uml_mcr_s mcr_ff;
    logic echoGate_ff;
    logic lineBreak_ff;
    logic [IRQ_SRCS-1:0] irqEnable_ff;
    logic [3:0] status_ff;
    logic [3:0] mask_ff;
    logic [3:0] prevModem_ff;
    logic [31:0] rdata_ff;
    logic slvErr_ff;
    logic portIrq_ff;
    logic modemIrq_ff;

    uml_pkg::uml_modem_s modemStatus;
    uml_pkg::uml_reg_e regSel;
    logic setupRd;
    logic accessWr;
    logic lowLane;
    logic [3:0] modemNow;
    logic [3:0] modemDelta;
    logic [3:0] w1c;
    logic [31:0] rdValue;
    logic gateOpen;
    logic wrMcr;
    logic wrSpc;
    logic wrIer;
    logic wrSts;
    logic wrMsk;
    logic wrBrk;
    logic unmapped;
    logic portReqHit;
    logic modemHit;
    // reset image of the status bits, indexed per bit by the loop below
    localparam logic [3:0] stsReset = `UML_STS_RST;

    // ************************************************************
    // address decode
    // ************************************************************
    always_comb begin
        case (paddr)
            `UML_OFS_MCR: begin
                regSel = uml_pkg::REG_MCR;
            end
            `UML_OFS_SPC: begin
                regSel = uml_pkg::REG_SPC;
            end
            `UML_OFS_IER: begin
                regSel = uml_pkg::REG_IER;
            end
            `UML_OFS_STS: begin
                regSel = uml_pkg::REG_STS;
            end
            `UML_OFS_MSK: begin
                regSel = uml_pkg::REG_MSK;
            end
            `UML_OFS_MSR: begin
                regSel = uml_pkg::REG_MSR;
            end
            `UML_OFS_BRK: begin
                regSel = uml_pkg::REG_BRK;
            end
            default: begin
                regSel = uml_pkg::REG_NONE;
            end
        endcase
    end

    // read data is captured in the setup cycle so prdata comes from a flop
    assign setupRd = psel & ~penable & ~pwrite;
    assign accessWr = psel & penable & pwrite & (regSel != uml_pkg::REG_NONE);
    // every field sits in the low byte, so only lane 0 can change anything
    assign lowLane = pstrb[0];
    assign pready = 1'b1;
    assign prdata = rdata_ff;
    assign pslverr = slvErr_ff;

    // ************************************************************
    // write strobes
    // ************************************************************
    // one strobe per register keeps every storage process to a single term
    assign wrMcr = accessWr & lowLane & (regSel == uml_pkg::REG_MCR);
    assign wrSpc = accessWr & lowLane & (regSel == uml_pkg::REG_SPC);
    assign wrIer = accessWr & lowLane & (regSel == uml_pkg::REG_IER);
    assign wrSts = accessWr & lowLane & (regSel == uml_pkg::REG_STS);
    assign wrMsk = accessWr & lowLane & (regSel == uml_pkg::REG_MSK);
    assign wrBrk = accessWr & lowLane & (regSel == uml_pkg::REG_BRK);
    // an unmapped access is flagged in setup and stands through access
    assign unmapped = (regSel == uml_pkg::REG_NONE);

    // ************************************************************
    // read mux
    // ************************************************************
    always_comb begin
        rdValue = 32'h0000_0000;
        case (regSel)
            uml_pkg::REG_MCR: begin
                rdValue[7:5] = `UML_MCR_RSVD; // R1
                rdValue[4:0] = mcr_ff;
            end
            uml_pkg::REG_SPC: begin
                rdValue[`UML_SPC_ECHO] = echoGate_ff;
            end
            uml_pkg::REG_IER: begin
                rdValue[IRQ_SRCS-1:0] = irqEnable_ff;
            end
            uml_pkg::REG_STS: begin
                rdValue[3:0] = status_ff;
            end
            uml_pkg::REG_MSK: begin
                rdValue[3:0] = mask_ff;
            end
            uml_pkg::REG_MSR: begin
                rdValue[3:0] = modemNow;
            end
            uml_pkg::REG_BRK: begin
                rdValue[`UML_BRK_LINE] = lineBreak_ff;
            end
            default: begin
                rdValue = 32'h0000_0000;
            end
        endcase
    end

    // ************************************************************
    // read data and error flops
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (setupRd) begin
            rdata_ff <= rdValue;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            slvErr_ff <= 1'b0;
        end else if (psel & ~penable) begin
            slvErr_ff <= unmapped;
        end
    end

    // ************************************************************
    // modem_line_control
    // ************************************************************
    // bits 7 to 5 have no storage, so writes there vanish
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mcr_ff <= `UML_MCR_RST; // R12
        end else if (wrMcr) begin
            mcr_ff <= pwdata[4:0]; // R1 R9 R12
        end
    end

    // ************************************************************
    // other control registers
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            echoGate_ff <= 1'b0;
        end else if (wrSpc) begin
            echoGate_ff <= pwdata[`UML_SPC_ECHO];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lineBreak_ff <= 1'b0;
        end else if (wrBrk) begin
            lineBreak_ff <= pwdata[`UML_BRK_LINE]; // R13
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqEnable_ff <= IRQ_SRCS'(`UML_IER_RST);
        end else if (wrIer) begin
            irqEnable_ff <= pwdata[IRQ_SRCS-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mask_ff <= `UML_MSK_RST;
        end else if (wrMsk) begin
            mask_ff <= pwdata[3:0];
        end
    end

    // ************************************************************
    // pin routing and loopback
    // ************************************************************
    uml_loop_route u_route (
        .sys_clk(sys_clk),
        .rst(rst),
        .mcr(mcr_ff),
        .lineBreak(lineBreak_ff),
        .txSerial(txSerial),
        .serialLinePin(serialLinePin),
        .serialTransmitPin(serialTransmitPin),
        .rxToDeser(rxToDeser),
        .modemPinN(modemPinN),
        .modemStatus(modemStatus),
        .rtsN(rtsN),
        .dtrN(dtrN),
        .spareOutN(spareOutN),
        .gateOutN(gateOutN)
    );

    assign modemNow = modemStatus;

    // ************************************************************
    // modem change events
    // ************************************************************
    // a write-one clear in the same cycle as a new change loses to the set
    assign w1c = wrSts ? pwdata[3:0] : 4'h0;

    // the previous image resets with the status path, so reset is no change;
    // entering or leaving loopback swaps the source and counts as a change
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prevModem_ff <= 4'h0;
        end else begin
            prevModem_ff <= modemNow;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_delta
            assign modemDelta[gi] = modemNow[gi] ^ prevModem_ff[gi];

            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    status_ff[gi] <= stsReset[gi];
                end else if (modemDelta[gi]) begin
                    status_ff[gi] <= 1'b1;
                end else if (w1c[gi]) begin
                    status_ff[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ************************************************************
    // interrupt outputs
    // ************************************************************
    // both outputs are flops, so a register write never glitches them
    assign modemHit = |(status_ff & mask_ff);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            modemIrq_ff <= 1'b0;
        end else begin
            modemIrq_ff <= modemHit;
        end
    end

    assign modemIrq = modemIrq_ff;

    // ************************************************************
    // serial port interrupt gate
    // ************************************************************
    // enabled requests are combined first, the gate only decides if they pass
    assign portReqHit = |(portIrqReq & irqEnable_ff);

    // in loopback the second output is busy driving carrier detect,
    // so a separate gate bit takes over its interrupt role
    always_comb begin
        if (mcr_ff.loop) begin
            gateOpen = echoGate_ff; // R7
        end else begin
            gateOpen = mcr_ff.gateOut; // R8
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            portIrq_ff <= 1'b0;
        end else begin
            portIrq_ff <= gateOpen & portReqHit; // R7 R8
        end
    end

    assign portIrq = portIrq_ff;

endmodule

`default_nettype wire

//--- uml_defs.svh
`ifndef UML_DEFS_SVH
`define UML_DEFS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define UML_OFS_MCR 12'h000
`define UML_OFS_SPC 12'h004
`define UML_OFS_IER 12'h008
`define UML_OFS_STS 12'h00c
`define UML_OFS_MSK 12'h010
`define UML_OFS_MSR 12'h014
`define UML_OFS_BRK 12'h018

// ************************************************************
// modem_line_control fields
// ************************************************************
`define UML_MCR_DTR 0
`define UML_MCR_RTS 1
`define UML_MCR_SPARE 2
`define UML_MCR_GATE 3
`define UML_MCR_LOOP 4
`define UML_MCR_RSVD 3'h7
`define UML_MCR_RST 5'h00

// ************************************************************
// other fields and reset values
// ************************************************************
`define UML_SPC_ECHO 0
`define UML_BRK_LINE 0
`define UML_IER_RST 4'h0
`define UML_STS_RST 4'h0
`define UML_MSK_RST 4'h0
`define UML_IDLE_MARK 1'b1

`endif

//--- uml_pkg.sv
`default_nettype none

package uml_pkg;

    // modem lines, active high inside the block
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } uml_modem_s;

    // writable part of modem_line_control, bit 4 down to bit 0
    typedef struct packed {
        logic loop;
        logic gateOut;
        logic spareOut;
        logic rts;
        logic dtr;
    } uml_mcr_s;

    typedef enum logic [2:0] {
        REG_MCR,
        REG_SPC,
        REG_IER,
        REG_STS,
        REG_MSK,
        REG_MSR,
        REG_BRK,
        REG_NONE
    } uml_reg_e;

endpackage

`default_nettype wire

//--- uml_loop_route.sv
`timescale 1ns/10ps
`default_nettype none

`include "uml_defs.svh"

module uml_loop_route (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // control
    input wire uml_pkg::uml_mcr_s mcr,
    input wire logic lineBreak,
    // serial data
    input wire logic txSerial,
    input wire logic serialLinePin,
    output logic serialTransmitPin,
    output logic rxToDeser,
    // modem lines
    input wire uml_pkg::uml_modem_s modemPinN,
    output uml_pkg::uml_modem_s modemStatus,
    output logic rtsN,
    output logic dtrN,
    output logic spareOutN,
    output logic gateOutN
);

    logic txLine;
    uml_pkg::uml_modem_s loopModem;

    // break drives the line low on either path
    assign txLine = txSerial & ~lineBreak; // R13

    always_comb begin
        loopModem.dsr = mcr.dtr; // R5
        loopModem.cts = mcr.rts; // R5
        loopModem.ri = mcr.spareOut; // R5
        loopModem.dcd = mcr.gateOut; // R5
    end

    // ************************************************************
    // registered pins
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            serialTransmitPin <= `UML_IDLE_MARK;
            rxToDeser <= `UML_IDLE_MARK;
        end else if (mcr.loop) begin
            serialTransmitPin <= `UML_IDLE_MARK; // R3
            rxToDeser <= txLine; // R2 R4 R6
        end else begin
            serialTransmitPin <= txLine; // R13
            rxToDeser <= serialLinePin;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            modemStatus <= '0;
        end else if (mcr.loop) begin
            modemStatus <= loopModem; // R5 R14
        end else begin
            modemStatus <= ~modemPinN;
        end
    end

    // modem outputs stay driven in loopback, only the modem inputs are cut off
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rtsN <= 1'b1;
            dtrN <= 1'b1;
            spareOutN <= 1'b1;
            gateOutN <= 1'b1;
        end else begin
            rtsN <= ~mcr.rts; // R10
            dtrN <= ~mcr.dtr; // R11
            spareOutN <= ~mcr.spareOut;
            gateOutN <= ~mcr.gateOut;
        end
    end

endmodule

`default_nettype wire

//--- uml_modem_loop_properties.sv
`timescale 1ns/10ps
`default_nettype none
module uml_modem_loop_properties #(
    parameter int IRQ_SRCS = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // line and modem
    input wire logic txSerial,
    input wire logic rxToDeser,
    input wire logic serialLinePin,
    input wire logic serialTransmitPin,
    input wire uml_pkg::uml_modem_s modemPinN,
    input wire logic rtsN,
    input wire logic dtrN,
    input wire logic spareOutN,
    input wire logic gateOutN,
    // interrupts
    input wire logic [IRQ_SRCS-1:0] portIrqReq,
    input wire logic portIrq,
    input wire logic modemIrq
);
    // ************************************************************
    // register shadows of every offset below 12'h01c, status included though it is set by hardware
    // ************************************************************
    logic [7:0] shadowFf [7];
    logic loopOn;
    logic brkOn;
    logic [3:0] mcrLow;
    logic irqExp;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < 7; i++) begin
                shadowFf[i] <= 8'h00;
            end
        end else if (psel && penable && pwrite && pready && pstrb[0] && paddr[1:0] == 2'b00 && paddr < 12'h01c) begin
            shadowFf[paddr[4:2]] <= pwdata[7:0];
        end
    end
    assign loopOn = shadowFf[0][4];
    assign brkOn = shadowFf[6][0];
    assign mcrLow = shadowFf[0][3:0];
    assign irqExp = (loopOn ? shadowFf[1][0] : shadowFf[0][3]) && |(portIrqReq & shadowFf[2][IRQ_SRCS-1:0]);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence mcrRead;
        psel && penable && !pwrite && paddr == 12'h000;
    endsequence
    mcr_read_back_a: assert property (mcrRead |-> prdata[7:0] == {3'h7, shadowFf[0][4:0]})
        else $error("control read back wrong");
    tx_idle_loop_a: assert property ($past(loopOn) |-> serialTransmitPin)
        else $error("transmit pin not idle");
    loop_rx_path_a: assert property ($past(loopOn) |-> rxToDeser == ($past(txSerial) & !$past(brkOn)))
        else $error("loop data wrong");
    normal_tx_path_a: assert property (!$past(loopOn) |-> serialTransmitPin == ($past(txSerial) & !$past(brkOn)))
        else $error("transmit pin wrong");
    normal_rx_path_a: assert property (!$past(loopOn) |-> rxToDeser == $past(serialLinePin))
        else $error("receive path wrong");
    rts_pin_level_a: assert property (rtsN == !$past(mcrLow[1]))
        else $error("rts pin wrong");
    dtr_pin_level_a: assert property (dtrN == !$past(mcrLow[0]))
        else $error("dtr pin wrong");
    general_outs_a: assert property ({gateOutN, spareOutN} == ~$past(mcrLow[3:2]))
        else $error("general outputs wrong");
    port_irq_gate_a: assert property (portIrq == $past(irqExp))
        else $error("port interrupt gate wrong");
endmodule
bind uml_modem_loop uml_modem_loop_properties #(.IRQ_SRCS(IRQ_SRCS)) props (.sys_clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .txSerial, .rxToDeser, .serialLinePin,
    .serialTransmitPin, .modemPinN, .rtsN, .dtrN, .spareOutN, .gateOutN, .portIrqReq, .portIrq, .modemIrq);
`default_nettype wire

//--- uml_line_model.sv
`timescale 1ns/10ps
`default_nettype none
module uml_line_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bench control
    input wire logic chatter,
    input wire logic lineLevel,
    input wire logic [3:0] modemLevelN,
    // line side
    output logic serialLinePin,
    output uml_pkg::uml_modem_s modemPinN
);
    // chatter toggles every cycle so a stale pin never passes for an ignored one
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            serialLinePin <= 1'b1;
            modemPinN <= 4'hf;
        end else if (chatter) begin
            serialLinePin <= !serialLinePin;
            modemPinN <= ~modemPinN;
        end else begin
            serialLinePin <= lineLevel;
            modemPinN <= modemLevelN;
        end
    end
endmodule
`default_nettype wire

//--- uml_modem_loop_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "uml_defs.svh"
module testbench;
    // ************************************************************
    // bench
    // ************************************************************
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic txSerial = 1'b1;
    logic chatter = 1'b0;
    logic lineLevel = 1'b1;
    logic [3:0] modemLevelN = 4'hf;
    logic [3:0] portIrqReq = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr, rxToDeser, serialLinePin, serialTransmitPin;
    logic rtsN, dtrN, spareOutN, gateOutN, portIrq, modemIrq;
    uml_pkg::uml_modem_s modemPinN;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    logic [4:0] loopMcr [2] = '{5'h1a, 5'h15};
    logic [3:0] loopSts [2] = '{4'h9, 4'h6};
    always #12.5 sys_clk = !sys_clk;
    uml_modem_loop #(.IRQ_SRCS(4)) dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .txSerial, .rxToDeser, .serialLinePin, .serialTransmitPin, .modemPinN,
        .rtsN, .dtrN, .spareOutN, .gateOutN, .portIrqReq, .portIrq, .modemIrq);
    uml_line_model line (.sys_clk, .rst, .chatter, .lineLevel, .modemLevelN, .serialLinePin, .modemPinN);
    task automatic summarize();
        if (failures == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] d,
        output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, wd, d, e);
    endtask
    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input logic expErr = 1'b0);
        logic [31:0] d;
        logic e;
        apb(1'b0, a, 32'h0, d, e);
        check(d, exp);
        check({31'h0, e}, {31'h0, expErr});
    endtask
    task automatic gap(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        check({rtsN, dtrN, spareOutN, gateOutN, serialTransmitPin, portIrq}, 6'h3e);
        rdChk(`UML_OFS_MCR, 32'he0);
        wr(`UML_OFS_MCR, 32'h0f);
        rdChk(`UML_OFS_MCR, 32'hef);
        gap(2);
        check({rtsN, dtrN, spareOutN, gateOutN}, 4'h0);
        wr(`UML_OFS_MCR, 32'h00);
        modemLevelN <= 4'ha;
        lineLevel <= 1'b0;
        gap(3);
        check(rxToDeser, 1'b0);
        rdChk(`UML_OFS_MSR, 32'h5);
        for (int i = 0; i < 2; i++) begin
            wr(`UML_OFS_MCR, {27'h0, loopMcr[i]});
            chatter <= 1'b1;
            txSerial <= 1'b0;
            gap(3);
            check({serialTransmitPin, rxToDeser}, 2'b10);
            rdChk(`UML_OFS_MSR, {28'h0, loopSts[i]});
            txSerial <= 1'b1;
            gap(2);
            check(rxToDeser, 1'b1);
            @(posedge sys_clk);
            chatter <= 1'b0;
        end
        portIrqReq <= 4'h1;
        wr(`UML_OFS_IER, 32'h1);
        gap(2);
        check(portIrq, 1'b0);
        wr(`UML_OFS_SPC, 32'h1);
        gap(2);
        check(portIrq, 1'b1);
        wr(`UML_OFS_MCR, 32'h00);
        gap(2);
        check(portIrq, 1'b0);
        wr(`UML_OFS_MCR, 32'h08);
        gap(2);
        check(portIrq, 1'b1);
        @(posedge sys_clk);
        pstrb <= 4'he;
        wr(`UML_OFS_MCR, 32'h1f);
        pstrb <= 4'hf;
        rdChk(`UML_OFS_MCR, 32'he8);
        wr(`UML_OFS_BRK, 32'h1);
        gap(2);
        check(serialTransmitPin, 1'b0);
        wr(`UML_OFS_BRK, 32'h0);
        gap(2);
        check(serialTransmitPin, 1'b1);
        wr(`UML_OFS_STS, 32'hf);
        wr(`UML_OFS_MSK, 32'h1);
        modemLevelN <= 4'hb;
        gap(4);
        check(modemIrq, 1'b1);
        rdChk(`UML_OFS_STS, 32'h1);
        wr(`UML_OFS_MSK, 32'h0);
        gap(2);
        check(modemIrq, 1'b0);
        wr(`UML_OFS_MSK, 32'h1);
        wr(`UML_OFS_STS, 32'h1);
        gap(2);
        check(modemIrq, 1'b0);
        rdChk(`UML_OFS_STS, 32'h0);
        rdChk(12'h020, 32'h0, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
